// ---- rsc_consts.svh ----
// Purpose: Constants for the resonance suppression control block
// Assumes: Wishbone byte offsets; 200 MHz system clock
// Notes: Definitions only
`ifndef RSC_CONSTS_SVH
`define RSC_CONSTS_SVH
`define RSC_LPF_IDX 10'h232
`define RSC_ADR_LPF 12'h8c8
`define RSC_ADR_N1F 12'h8c0
`define RSC_ADR_N1A 12'h8c4
`define RSC_ADR_N2F 12'h958
`define RSC_ADR_N2A 12'h960
`define RSC_ADR_N3F 12'h968
`define RSC_ADR_N3A 12'h970
`define RSC_ADR_MODE 12'h978
`define RSC_ADR_STAT 12'h97c
`define RSC_ADR_DET 12'h980
`define RSC_FREQ_DEF 16'h03e8
`define RSC_FREQ_MIN 16'h0032
`define RSC_FREQ_MAX 16'h03e8
`define RSC_ATT_MAX 16'h0020
`define RSC_LPF_MAX 16'h03e8
`define RSC_LPF_DEF 16'h0002
`define RSC_ZERO16 16'h0000
`define RSC_STABLE_MIN 20
`define RSC_CLK_HZ 200000000
`define RSC_SAMPLE_US 16'h0064
`define RSC_CYC_PER_SAMPLE ((`RSC_CLK_HZ / 1000000) * 100)
`define RSC_STABLE_CYC (64'd60 * `RSC_STABLE_MIN * `RSC_CLK_HZ)
`endif

// ---- rsc_ctrl.sv ----
// Purpose: Resonance suppression control: low-pass, three notch sets, auto mode
// Assumes: Classic Wishbone slave, one clock, synchronous active-low reset
// Notes: Resonance search itself is external; detections arrive as a strobe
//
// Behaviour
// RULE1: Zero time constant bypasses low-pass filter
// RULE2: Time constant 0..1000 in 0.1 ms
// RULE3: Two auto notch sets, frequency plus attenuation
// RULE4: Modes 1 or 2 search and suppress
// RULE5: Detections stored into notch two, three
// RULE6: Mode 1 self-clears after 20 stable minutes
// RULE7: Mode 2 never self-clears
// RULE8: Write 1, or 2 from 0, clears four
// RULE9: Write 2 from active keeps settings
// RULE10: Write 0 from active keeps, disables
// RULE11: Frequencies 50..1000 Hz, attenuation 0..32 dB
// RULE12: Nonzero attenuation marks auto-found frequency
// RULE13: Attenuation 32: operator lowers bandwidth
// RULE14: Below 32: operator disables, raises manually
// RULE15: Out-of-range frequency: operator uses low-pass
// RULE16: Zero attenuation disables that notch
// RULE17: Low-pass is first-order recursive filter
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_ctrl #(
   parameter logic [63:0] STABLE_CYC = `RSC_STABLE_CYC
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic WB_CYC_I,
   input wire logic WB_STB_I,
   input wire logic WB_WE_I,
   input wire logic [11:0] WB_ADR_I,
   input wire logic [3:0] WB_SEL_I,
   input wire logic [31:0] WB_DAT_I,
   output logic [31:0] WB_DAT_O,
   output logic WB_ACK_O,
   input wire logic DET_VALID,
   input wire logic DET_SET,
   input wire logic [15:0] DET_FREQ,
   input wire logic [15:0] DET_ATT,
   input wire logic DET_DONE,
   input wire logic RES_PRESENT,
   input wire logic signed [15:0] LPF_IN,
   output logic signed [15:0] LPF_OUT,
   output logic SEARCH_EN,
   output logic [15:0] NOTCH1_FREQ,
   output logic [15:0] NOTCH1_ATT,
   output logic NOTCH1_EN,
   output logic [15:0] NOTCH2_FREQ,
   output logic [15:0] NOTCH2_ATT,
   output logic NOTCH2_EN,
   output logic [15:0] NOTCH3_FREQ,
   output logic [15:0] NOTCH3_ATT,
   output logic NOTCH3_EN
);
   logic [15:0] lpf_q;
   logic [15:0] f1_q, a1_q, f2_q, a2_q, f3_q, a3_q;
   rsc_pkg::rsc_mode_e mode_q;
   logic done_q;
   logic [63:0] stab_q;
   logic [15:0] smp_q;
   logic smp_en;
   logic ack_q;
   logic [31:0] dat_q;
   logic req;
   logic wr;
   logic wlo;
   logic [15:0] wdat;
   logic active;
   logic mode_wr;
   logic clear_all;
   logic self_clear;

   // Clamp a frequency into the notch range
   function automatic logic [15:0] clamp_freq(input logic [15:0] v);
      if (v < `RSC_FREQ_MIN) clamp_freq = `RSC_FREQ_MIN;
      else if (v > `RSC_FREQ_MAX) clamp_freq = `RSC_FREQ_MAX;
      else clamp_freq = v;
   endfunction

   // Clamp an attenuation to its top value
   function automatic logic [15:0] clamp_att(input logic [15:0] v);
      clamp_att = (v > `RSC_ATT_MAX) ? `RSC_ATT_MAX : v;
   endfunction

   // Bus decode; single-cycle ack after one wait state
   assign req = WB_CYC_I && WB_STB_I && !ack_q;
   assign wr = req && WB_WE_I;
   assign wlo = WB_SEL_I[0] && WB_SEL_I[1];
   assign wdat = WB_DAT_I[15:0];
   assign active = (mode_q != rsc_pkg::RSC_OFF); // RULE4
   assign mode_wr = wr && wlo && (WB_ADR_I == `RSC_ADR_MODE);
   // One always clears; two clears only when starting from off
   assign clear_all = mode_wr && ((wdat[1:0] == 2'b01) ||
      ((wdat[1:0] == 2'b10) && !active)); // RULE8 RULE9
   assign self_clear = (mode_q == rsc_pkg::RSC_ONCE) && done_q &&
      (stab_q >= STABLE_CYC - 64'h1); // RULE6

   // Ack register, drops the cycle after
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) ack_q <= 1'b0;
      else ack_q <= req;
   end
   assign WB_ACK_O = ack_q;

   // Read data, unmapped reads return zero
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         dat_q <= 32'h0;
      end else if (req && !WB_WE_I) begin
         unique case (WB_ADR_I)
            `RSC_ADR_LPF: dat_q <= {16'h0, lpf_q};
            `RSC_ADR_N1F: dat_q <= {16'h0, f1_q};
            `RSC_ADR_N1A: dat_q <= {16'h0, a1_q};
            `RSC_ADR_N2F: dat_q <= {16'h0, f2_q};
            `RSC_ADR_N2A: dat_q <= {16'h0, a2_q};
            `RSC_ADR_N3F: dat_q <= {16'h0, f3_q};
            `RSC_ADR_N3A: dat_q <= {16'h0, a3_q};
            `RSC_ADR_MODE: dat_q <= {30'h0, mode_q};
            `RSC_ADR_STAT: dat_q <= {28'h0, (a2_q == `RSC_ATT_MAX) || (a3_q == `RSC_ATT_MAX),
               (a2_q != 16'h0) && (a3_q != 16'h0), done_q, active}; // RULE12 RULE13
            default: dat_q <= 32'h0;
         endcase
      end
   end
   assign WB_DAT_O = dat_q;

   // Low-pass constant; out-of-range writes saturate at 1000
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) lpf_q <= `RSC_LPF_DEF;
      else if (wr && wlo && WB_ADR_I == `RSC_ADR_LPF)
         lpf_q <= (wdat > `RSC_LPF_MAX) ? `RSC_LPF_MAX : wdat; // RULE2
   end

   // Manual notch one, never touched by auto mode
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         f1_q <= `RSC_FREQ_DEF;
         a1_q <= `RSC_ZERO16;
      end else if (wr && wlo) begin
         if (WB_ADR_I == `RSC_ADR_N1F) f1_q <= clamp_freq(wdat); // RULE11
         if (WB_ADR_I == `RSC_ADR_N1A) a1_q <= clamp_att(wdat); // RULE11
      end
   end

   // Auto notch sets; clear beats detection, detection beats software
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         f2_q <= `RSC_FREQ_DEF;
         a2_q <= `RSC_ZERO16;
         f3_q <= `RSC_FREQ_DEF;
         a3_q <= `RSC_ZERO16;
      end else if (clear_all) begin // RULE8
         f2_q <= `RSC_FREQ_DEF; // RULE12
         a2_q <= `RSC_ZERO16;
         f3_q <= `RSC_FREQ_DEF;
         a3_q <= `RSC_ZERO16;
      end else if (DET_VALID && active) begin // RULE5 RULE3
         if (!DET_SET) begin
            f2_q <= clamp_freq(DET_FREQ);
            a2_q <= clamp_att(DET_ATT);
         end else begin
            f3_q <= clamp_freq(DET_FREQ);
            a3_q <= clamp_att(DET_ATT);
         end
      end else if (wr && wlo) begin
         if (WB_ADR_I == `RSC_ADR_N2F) f2_q <= clamp_freq(wdat); // RULE11
         if (WB_ADR_I == `RSC_ADR_N2A) a2_q <= clamp_att(wdat);
         if (WB_ADR_I == `RSC_ADR_N3F) f3_q <= clamp_freq(wdat);
         if (WB_ADR_I == `RSC_ADR_N3A) a3_q <= clamp_att(wdat);
      end
   end

   // Mode register; software write wins over self-clear
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) mode_q <= rsc_pkg::RSC_OFF;
      else if (mode_wr) begin
         unique case (wdat[1:0])
            2'b00: mode_q <= rsc_pkg::RSC_OFF; // RULE10
            2'b01: mode_q <= rsc_pkg::RSC_ONCE;
            2'b10: mode_q <= rsc_pkg::RSC_CONT; // RULE9
            default: mode_q <= mode_q;
         endcase
      end else if (self_clear) mode_q <= rsc_pkg::RSC_OFF; // RULE6 RULE7
   end

   // Completion flag: set wins over restart clear
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) done_q <= 1'b0;
      else if (DET_DONE && active) done_q <= 1'b1;
      else if (mode_wr || !active) done_q <= 1'b0;
   end

   // Stability timer restarts whenever resonance shows again
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) stab_q <= 64'h0;
      else if (!done_q || RES_PRESENT || mode_wr || self_clear) stab_q <= 64'h0;
      else stab_q <= stab_q + 64'h1;
   end

   // Control-loop sample enable, 100 us period
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) smp_q <= 16'h0;
      else if (smp_en) smp_q <= 16'h0;
      else smp_q <= smp_q + 16'h1;
   end
   assign smp_en = (smp_q == 16'(`RSC_CYC_PER_SAMPLE - 1));

   rsc_lpf u_lpf (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .smp_en(smp_en),
      .tau(lpf_q),
      .din(LPF_IN),
      .dout(LPF_OUT)
   );

   // Filter outputs; zero attenuation disables a notch
   assign SEARCH_EN = active; // RULE4
   assign NOTCH1_FREQ = f1_q;
   assign NOTCH1_ATT = a1_q;
   assign NOTCH1_EN = (a1_q != `RSC_ZERO16); // RULE16
   assign NOTCH2_FREQ = f2_q;
   assign NOTCH2_ATT = a2_q;
   assign NOTCH2_EN = (a2_q != `RSC_ZERO16); // RULE16
   assign NOTCH3_FREQ = f3_q;
   assign NOTCH3_ATT = a3_q;
   assign NOTCH3_EN = (a3_q != `RSC_ZERO16); // RULE16

   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N);

   property p_ack;
      req |=> WB_ACK_O ##1 !WB_ACK_O;
   endproperty
   a_ack: assert property (p_ack) else $error("ack timing wrong");
   property p_clear;
      clear_all |=> (a2_q == 16'h0) && (a3_q == 16'h0) && (f2_q == `RSC_FREQ_DEF);
   endproperty
   a_clear: assert property (p_clear) else $error("notch sets not cleared"); // RULE8
   property p_keep;
      (mode_wr && wdat[1:0] == 2'b10 && active && !DET_VALID) |=> $stable(a2_q) && $stable(f3_q);
   endproperty
   a_keep: assert property (p_keep) else $error("notch sets lost on mode 2"); // RULE9
   property p_off;
      (mode_wr && wdat[1:0] == 2'b00 && active) |=> !SEARCH_EN && $stable(a3_q);
   endproperty
   a_off: assert property (p_off) else $error("mode 0 write wrong"); // RULE10
   property p_cont;
      (mode_q == rsc_pkg::RSC_CONT && !mode_wr) |=> mode_q == rsc_pkg::RSC_CONT;
   endproperty
   a_cont: assert property (p_cont) else $error("mode 2 cleared itself"); // RULE7
   property p_self;
      self_clear && !mode_wr |=> mode_q == rsc_pkg::RSC_OFF;
   endproperty
   a_self: assert property (p_self) else $error("mode 1 not cleared"); // RULE6
   property p_en;
      NOTCH2_EN == (a2_q != 16'h0) && NOTCH3_EN == (a3_q != 16'h0);
   endproperty
   a_en: assert property (p_en) else $error("notch enable wrong"); // RULE16
   property p_range;
      f2_q >= `RSC_FREQ_MIN && f2_q <= `RSC_FREQ_MAX && a3_q <= `RSC_ATT_MAX;
   endproperty
   a_range: assert property (p_range) else $error("notch out of range"); // RULE11
   property p_lpf;
      lpf_q <= `RSC_LPF_MAX;
   endproperty
   a_lpf: assert property (p_lpf) else $error("time constant out of range"); // RULE2
   property p_det;
      (DET_VALID && active && !DET_SET && !clear_all) |=> f2_q == $past(clamp_freq(DET_FREQ));
   endproperty
   a_det: assert property (p_det) else $error("detection not stored"); // RULE5
   property p_byp;
      (smp_en && lpf_q == 16'h0) |=> LPF_OUT == $past(LPF_IN);
   endproperty
   a_byp: assert property (p_byp) else $error("bypass failed"); // RULE1
   // Refused writes and idle detections leave state alone
   property p_sel;
      (wr && !wlo) |=> $stable(lpf_q) && $stable(f1_q) && $stable(a1_q);
   endproperty
   a_sel: assert property (p_sel) else $error("write without low lanes landed"); // RULE2
   property p_mode3;
      (mode_wr && wdat[1:0] == 2'b11 && !self_clear) |=> $stable(mode_q);
   endproperty
   a_mode3: assert property (p_mode3) else $error("reserved mode code taken"); // RULE4
   property p_idle;
      (DET_VALID && !active && !wr) |=>
         $stable(f2_q) && $stable(a2_q) && $stable(f3_q) && $stable(a3_q);
   endproperty
   a_idle: assert property (p_idle) else $error("detection stored while off"); // RULE4

   // Self-clear only after completion and a quiet spell
   property p_wait;
      (mode_q == rsc_pkg::RSC_ONCE && !done_q && !mode_wr) |=> mode_q == rsc_pkg::RSC_ONCE;
   endproperty
   a_wait: assert property (p_wait) else $error("mode 1 left before completion"); // RULE6
   property p_stab;
      RES_PRESENT |=> stab_q == 64'h0;
   endproperty
   a_stab: assert property (p_stab) else $error("stable timer ran with resonance"); // RULE6
   property p_done;
      (DET_DONE && active) |=> done_q;
   endproperty
   a_done: assert property (p_done) else $error("completion not recorded"); // RULE6

   // Auto results and restarts
   property p_det3;
      (DET_VALID && active && DET_SET && !clear_all) |=> a3_q == $past(clamp_att(DET_ATT));
   endproperty
   a_det3: assert property (p_det3) else $error("set three not stored"); // RULE5
   property p_clr3;
      clear_all |=> (f3_q == `RSC_FREQ_DEF) && !NOTCH2_EN && !NOTCH3_EN;
   endproperty
   a_clr3: assert property (p_clr3) else $error("cleared notch still enabled"); // RULE12
   property p_one;
      clear_all |=> $stable(f1_q) && $stable(a1_q);
   endproperty
   a_one: assert property (p_one) else $error("manual notch touched by clear"); // RULE3

   // Read path returns what the registers held at the request
   property p_rdmode;
      (req && !WB_WE_I && WB_ADR_I == `RSC_ADR_MODE) |=> WB_DAT_O == {30'h0, $past(mode_q)};
   endproperty
   a_rdmode: assert property (p_rdmode) else $error("mode read wrong"); // RULE4
   property p_rdlpf;
      (req && !WB_WE_I && WB_ADR_I == `RSC_ADR_LPF) |=> WB_DAT_O == {16'h0, $past(lpf_q)};
   endproperty
   a_rdlpf: assert property (p_rdlpf) else $error("time constant read wrong"); // RULE2

   // Filter output moves only on a sample enable
   property p_hold;
      !smp_en |=> $stable(LPF_OUT);
   endproperty
   a_hold: assert property (p_hold) else $error("filter moved between samples"); // RULE17

   // Scenario covers
   c_clear: cover property (clear_all);
   c_det: cover property (DET_VALID && active);
   c_self: cover property (self_clear);
   c_cont: cover property (mode_q == rsc_pkg::RSC_CONT && DET_VALID);
   c_keep: cover property (mode_wr && wdat[1:0] == 2'b10 && active);
endmodule // rsc_ctrl

// ---- rsc_ctrl_bench.sv ----
// Purpose: Self-checking bench for the resonance suppression control block
// Assumes: Stable period shortened to 50 cycles; one-cycle bus answer
// Notes: Outputs read at rising edges, before that edge's updates land
`timescale 1ns/1ps
`include "rsc_consts.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin miscompares++; \
$display("CHECK FAILED t=%0t got %h", $time, a); end end
module rsc_ctrl_bench;
   logic clk, rst_n, cyc, stb, we, ack, res, det_v, det_s, det_d;
   logic [11:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q;
   logic [15:0] det_f, det_a, n1f, n1a, n2f, n2a, n3f, n3a;
   logic n1e, n2e, n3e, srch;
   logic signed [15:0] lin, lout;
   int miscompares = 0;
   int samples_checked = 0;
   int n;

   rsc_ctrl #(.STABLE_CYC(64'h32)) dut (.CLK_SYS(clk), .RST_N(rst_n), .WB_CYC_I(cyc),
      .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat),
      .WB_DAT_O(rdat), .WB_ACK_O(ack), .DET_VALID(det_v), .DET_SET(det_s),
      .DET_FREQ(det_f), .DET_ATT(det_a), .DET_DONE(det_d), .RES_PRESENT(res),
      .LPF_IN(lin), .LPF_OUT(lout), .SEARCH_EN(srch), .NOTCH1_FREQ(n1f),
      .NOTCH1_ATT(n1a), .NOTCH1_EN(n1e), .NOTCH2_FREQ(n2f), .NOTCH2_ATT(n2a),
      .NOTCH2_EN(n2e), .NOTCH3_FREQ(n3f), .NOTCH3_ATT(n3a), .NOTCH3_EN(n3e));
   rsc_srch_model sm (.clk(clk), .det_valid(det_v), .det_set(det_s), .det_freq(det_f),
      .det_att(det_a), .det_done(det_d));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic results();
      if (miscompares == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   // Classic cycle; held until ack is sampled, lost answer ends the run
   task automatic wb(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 20);
      if (ack !== 1'b1) begin
         miscompares++;
         results();
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rd(input logic [11:0] a, input logic [15:0] e);
      wb(1'b0, a, 32'h0, 4'hf);
      `CHK(q, {16'h0, e})
   endtask
   task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [3:0] s = 4'hf);
      wb(1'b1, a, {16'h0, d}, s);
   endtask
   task automatic nap(input int c);
      repeat (c) @(posedge clk);
   endtask

   task automatic t_reset();
      rd(`RSC_ADR_LPF, `RSC_LPF_DEF);
      rd(`RSC_ADR_N2F, `RSC_FREQ_DEF);
      rd(`RSC_ADR_N3A, 16'h0);
      rd(`RSC_ADR_MODE, 16'h0);
      rd(`RSC_ADR_DET, 16'h0);
      `CHK({srch, n1e, n2e, n3e}, 4'h0)
   endtask

   // Clamping, refused byte lanes, notch enable from attenuation
   task automatic t_manual();
      wr(`RSC_ADR_N1F, 16'h7d0);
      rd(`RSC_ADR_N1F, `RSC_FREQ_MAX);
      wr(`RSC_ADR_N1F, 16'h28);
      rd(`RSC_ADR_N1F, `RSC_FREQ_MIN);
      wr(`RSC_ADR_N1A, 16'h5, 4'h0);
      rd(`RSC_ADR_N1A, 16'h0);
      wr(`RSC_ADR_N1A, 16'h28);
      nap(2);
      `CHK({n1e, n1a, n1f}, {1'b1, `RSC_ATT_MAX, `RSC_FREQ_MIN})
      wr(`RSC_ADR_N1A, 16'h0);
      nap(2);
      `CHK(n1e, 1'b0)
      wr(`RSC_ADR_LPF, 16'h7d0);
      rd(`RSC_ADR_LPF, `RSC_LPF_MAX);
   endtask

   // Mode transitions 0 to 1, 1 to 2, 2 to 0, 0 to 2 and 2 to 1 against the notch settings
   task automatic t_auto();
      wr(`RSC_ADR_MODE, 16'h1);
      nap(2);
      `CHK(srch, 1'b1)
      sm.detect(1'b0, 16'h12c, 16'ha);
      sm.detect(1'b1, 16'h258, 16'h20);
      nap(3);
      `CHK({n2f, n2a, n3f, n3a}, {16'h12c, 16'ha, 16'h258, 16'h20})
      `CHK({n2e, n3e}, 2'h3)
      rd(`RSC_ADR_STAT, 16'hd);
      wr(`RSC_ADR_MODE, 16'h2);
      rd(`RSC_ADR_N3F, 16'h258);
      wr(`RSC_ADR_MODE, 16'h0);
      rd(`RSC_ADR_N2A, 16'ha);
      `CHK(srch, 1'b0)
      wr(`RSC_ADR_N2A, 16'h14);
      rd(`RSC_ADR_N2A, 16'h14);
      wr(`RSC_ADR_MODE, 16'h2);
      nap(2);
      `CHK({n2e, n2f, n3a, srch}, {1'b0, `RSC_FREQ_DEF, 16'h0, 1'b1})
      sm.detect(1'b0, 16'h12c, 16'ha);
      wr(`RSC_ADR_MODE, 16'h1);
      nap(2);
      `CHK({n2f, n2a}, {`RSC_FREQ_DEF, 16'h0})
   endtask

   // Resonance holds the timer off; mode 2 never clears itself
   task automatic t_stable();
      res <= 1'b1;
      sm.sup_done();
      nap(100);
      rd(`RSC_ADR_MODE, 16'h1);
      res <= 1'b0;
      nap(30);
      rd(`RSC_ADR_MODE, 16'h1);
      nap(40);
      rd(`RSC_ADR_MODE, 16'h0);
      wr(`RSC_ADR_MODE, 16'h2);
      sm.sup_done();
      nap(100);
      rd(`RSC_ADR_MODE, 16'h2);
   endtask

   // Bypass at zero, slow first-order response at the longest constant
   task automatic t_lpf();
      wr(`RSC_ADR_LPF, 16'h0);
      lin <= 16'sh1234;
      for (n = 0; n < 20100 && lout !== 16'sh1234; n++) @(posedge clk);
      `CHK(lout, 16'sh1234)
      wr(`RSC_ADR_LPF, 16'h3e8);
      lin <= 16'sh0;
      nap(20100);
      `CHK(lout < 16'sh1234 && lout > 16'sh1220, 1'b1)
   endtask

   // Inputs settled at time zero, reset for four cycles
   initial begin
      rst_n = 1'b0;
      {cyc, stb, we, res} = 4'h0;
      adr = 12'h0;
      sel = 4'h0;
      wdat = 32'h0;
      lin = 16'sh0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_manual();
      t_auto();
      t_stable();
      t_lpf();
      results();
   end
endmodule // rsc_ctrl_bench

// ---- rsc_lpf.sv ----
// Purpose: First-order recursive low-pass filter with bypass
// Assumes: One sample enable per control period
// Notes: Coefficient alpha = Ts/(tau+Ts), Q16
`timescale 1ns/1ps
`include "rsc_consts.svh"
module rsc_lpf (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic smp_en,
   input wire logic [15:0] tau,
   input wire logic signed [15:0] din,
   output logic signed [15:0] dout
);
   logic signed [31:0] acc_q;
   logic [16:0] alpha;
   logic signed [32:0] diff;
   logic signed [50:0] prod;
   logic signed [33:0] step;
   // Ts in 0.1 ms units is 1, so alpha = 65536/(tau+1)
   assign alpha = 17'(32'h00010000 / (32'(tau) + 32'h1));
   // Error needs 33 bits and the product 51, or large steps wrap
   assign diff = $signed({din[15], din, 16'h0000}) - $signed({acc_q[31], acc_q});
   assign prod = 51'(diff) * 51'($signed({1'b0, alpha}));
   assign step = 34'(prod >>> 16);
   // Accumulator in Q16; zero constant bypasses entirely
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         acc_q <= 32'sh0;
         dout <= 16'sh0;
      end else if (smp_en) begin
         if (tau == `RSC_ZERO16) begin // RULE1
            acc_q <= {din, 16'h0000};
            dout <= din;
         end else begin // RULE17
            acc_q <= acc_q + 32'(step);
            dout <= 16'((acc_q + 32'(step)) >>> 16);
         end
      end
   end
endmodule // rsc_lpf

// ---- rsc_pkg.sv ----
// Purpose: Types for the resonance suppression control block
// Assumes: Constants come from rsc_consts.svh
// Notes: Types only
package rsc_pkg;
   typedef enum logic [1:0] {
      RSC_OFF = 2'b00,
      RSC_ONCE = 2'b01,
      RSC_CONT = 2'b10
   } rsc_mode_e;
   typedef logic [15:0] rsc_word_t;
endpackage

// ---- rsc_srch_model.sv ----
// Purpose: Resonance search engine model feeding detections to the control block
// Assumes: Driven from the bench clock, changes just after rising edges
// Notes: Released data lines show the inverse of the last value, not a stale copy
`timescale 1ns/1ps
module rsc_srch_model (
   input wire logic clk,
   output logic det_valid,
   output logic det_set,
   output logic [15:0] det_freq,
   output logic [15:0] det_att,
   output logic det_done
);
   // Idle lines at time zero
   initial begin
      det_valid = 1'b0;
      det_set = 1'b0;
      det_freq = 16'h0;
      det_att = 16'h0;
      det_done = 1'b0;
   end

   // One-cycle detection; results are driven exactly as given, with no range limits
   task automatic detect(input logic s, input logic [15:0] f, input logic [15:0] a);
      @(posedge clk);
      det_valid <= 1'b1;
      det_set <= s;
      det_freq <= f;
      det_att <= a;
      @(posedge clk);
      det_valid <= 1'b0;
      det_freq <= ~f;
      det_att <= ~a;
   endtask

   // Suppression finished pulse
   task automatic sup_done();
      @(posedge clk);
      det_done <= 1'b1;
      @(posedge clk);
      det_done <= 1'b0;
   endtask
endmodule // rsc_srch_model
